/* File: dds_pkg.sv */
// package with constants and types for the dual channel dma sequencer
`default_nettype none
package dds_pkg;
  localparam int          DDS_NUM_CH      = 2;
  localparam int          DDS_ADDR_W      = 20;
  localparam int          DDS_CNT_W       = 16;
  localparam int          DDS_SRC_W       = 2;
  localparam int          DDS_CYC_W       = 4;
  // request source selection codes
  localparam logic [1:0]  DDS_SRC_PERIPH  = 2'h0;
  localparam logic [1:0]  DDS_SRC_SOFT    = 2'h1;
  localparam logic [1:0]  DDS_SRC_EXT_FALL = 2'h2;
  localparam logic [1:0]  DDS_SRC_EXT_RISE = 2'h3;
  // region class codes and their cycle coefficients
  localparam logic [2:0]  DDS_RGN_INT_NOWAIT = 3'h0;
  localparam logic [2:0]  DDS_RGN_INT_WAIT   = 3'h1;
  localparam logic [2:0]  DDS_RGN_SFR_DISP   = 3'h2;
  localparam logic [2:0]  DDS_RGN_EXT_NOWAIT = 3'h3;
  localparam logic [2:0]  DDS_RGN_EXT_WAIT   = 3'h4;
  localparam logic [2:0]  DDS_RGN_EXT_MUX    = 3'h5;
  localparam logic [1:0]  DDS_COEF_ONE    = 2'h1;
  localparam logic [1:0]  DDS_COEF_TWO    = 2'h2;
  localparam logic [1:0]  DDS_COEF_THREE  = 2'h3;
  localparam logic [1:0]  DDS_CYC_ONE     = 2'h1;
  localparam logic [1:0]  DDS_CYC_TWO     = 2'h2;
  // processor modes
  localparam logic [1:0]  DDS_MODE_SINGLE = 2'h0;
  localparam logic [1:0]  DDS_MODE_EXPAND = 2'h1;
  localparam logic [1:0]  DDS_MODE_PROC   = 2'h2;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    DDS_ST_IDLE = 4'h1,
    DDS_ST_XFER = 4'h2,
    DDS_ST_CPU  = 4'h4,
    DDS_ST_HOLD = 4'h8
  } dds_state_t;
endpackage
`default_nettype wire

/* File: dds_cycle_calc.sv */
// transfer unit cycle count for one channel
`default_nettype none
module dds_cycle_calc
  import dds_pkg::*;
(
  // transfer shape
  input  wire logic [DDS_ADDR_W-1:0] i_src_addr,
  input  wire logic [DDS_ADDR_W-1:0] i_dst_addr,
  input  wire logic                  i_unit_size_bit,
  input  wire logic                  i_bus8,
  input  wire logic [2:0]            i_src_rgn,
  input  wire logic [2:0]            i_dst_rgn,
  // result
  output logic      [DDS_CYC_W-1:0]  o_cycles,
  output logic                       o_illegal
);
  logic [1:0] rd_cyc;
  logic [1:0] wr_cyc;
  logic [1:0] src_coef;
  logic [1:0] dst_coef;

  function automatic logic [1:0] coef(input logic [2:0] rgn);
    logic [1:0] c;
    c = DDS_COEF_ONE;
    if (rgn == DDS_RGN_INT_WAIT || rgn == DDS_RGN_SFR_DISP || rgn == DDS_RGN_EXT_WAIT)
      c = DDS_COEF_TWO;
    else if (rgn == DDS_RGN_EXT_MUX)
      c = DDS_COEF_THREE;
    return c;
  endfunction

  // any parity is accepted; odd only costs extra cycles on word units
  assign rd_cyc   = i_unit_size_bit ? DDS_CYC_ONE :                 // R01 R04
                    (i_bus8 || i_src_addr[0]) ? DDS_CYC_TWO : DDS_CYC_ONE; // R05 R06
  assign wr_cyc   = i_unit_size_bit ? DDS_CYC_ONE :                 // R04
                    (i_bus8 || i_dst_addr[0]) ? DDS_CYC_TWO : DDS_CYC_ONE; // R05 R06
  assign src_coef = coef(i_src_rgn);                                // R03
  assign dst_coef = coef(i_dst_rgn);                                // R03
  assign o_cycles = 4'(rd_cyc * src_coef) + 4'(wr_cyc * dst_coef);  // R02
  assign o_illegal = (i_src_rgn > DDS_RGN_EXT_MUX) || (i_dst_rgn > DDS_RGN_EXT_MUX);
endmodule
`default_nettype wire

/* File: dds_req_latch.sv */
// request bit of one channel with source selection
`default_nettype none
module dds_req_latch
  import dds_pkg::*;
(
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rstn,
  // sources
  input  wire logic [DDS_SRC_W-1:0] i_src_sel,
  input  wire logic                 i_periph_irq,
  input  wire logic                 i_soft_trig,
  input  wire logic                 i_external_request_pin,
  // clears
  input  wire logic                 i_sw_clr,
  input  wire logic                 i_start_clr,
  // state
  output logic                      o_req
);
  logic pin_d;
  logic req;
  logic fire;
  logic fall;
  logic rise;

  assign fall  = pin_d & ~i_external_request_pin;
  assign rise  = ~pin_d & i_external_request_pin;
  assign fire  = (i_src_sel == DDS_SRC_PERIPH   && i_periph_irq) ||  // R13 R14
                 (i_src_sel == DDS_SRC_SOFT     && i_soft_trig)  ||  // R13
                 (i_src_sel == DDS_SRC_EXT_FALL && fall)         ||  // R15
                 (i_src_sel == DDS_SRC_EXT_RISE && rise);            // R15
  assign o_req = req;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pin_d <= 1'b1;
      req   <= 1'b0;
    end
    else
    begin
      pin_d <= i_external_request_pin;
      // a new request beats a clear in the same cycle
      if (fire)
        req <= 1'b1;                                                 // R09
      else if (i_sw_clr || i_start_clr)
        req <= 1'b0;                                                 // R10 R11
    end
  end
endmodule
`default_nettype wire

/* File: dds_sequencer.sv */
// two channel dma sequencer: requests, priority, reload and bus hand-back
// How it works
// R01 - any source and destination parity accepted
// R02 - cycles equal reads times j plus writes times k
// R03 - coefficients 1,2,2,1,2,3 by region class
// R04 - byte unit: one read, one write
// R05 - word, 16-bit bus: odd address doubles
// R06 - word on 8-bit bus: two each
// R07 - first transfer reloads pointer and counter
// R08 - rewriting enable restarts from initial state
// R09 - request sets regardless of enable
// R10 - request cleared just before transfer starts
// R11 - software writes zero clears, one ignored
// R12 - software clears request after source change
// R13 - one preselected request source per channel
// R14 - peripheral request timed with its interrupt
// R15 - external pin edge per selection sets request
// R16 - simultaneous requests: channel 0 goes first
// R17 - bus returns to cpu after each transfer
// R18 - transfers ignore cpu interrupt flag, level
// R19 - 8-bit pin width applies to internal areas
// R20 - one unit per bus grant
`default_nettype none
module dds_sequencer
  import dds_pkg::*;
(
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  // mode and bus width
  input  wire logic [1:0]            i_proc_mode,
  input  wire logic                  i_bus8_pin,
  input  wire logic                  i_cpu_if_flag,
  // channel control, one bit per channel; i_src_sel two bits per channel
  input  wire logic [1:0]            i_enable_wr,
  input  wire logic [1:0]            i_enable_val,
  input  wire logic [1:0]            i_req_wr0,
  input  wire logic [1:0]            i_unit_size_bit,
  input  wire logic [1:0]            i_dir_from_src,
  input  wire logic [1:0]            i_soft_trig,
  input  wire logic [1:0]            i_periph_irq,
  input  wire logic [1:0]            i_external_request_pin,
  input  wire logic [3:0]            i_src_sel,
  // per channel setup
  input  wire logic [DDS_ADDR_W-1:0] i_src_ptr0,
  input  wire logic [DDS_ADDR_W-1:0] i_dst_ptr0,
  input  wire logic [DDS_CNT_W-1:0]  i_reload0,
  input  wire logic [DDS_ADDR_W-1:0] i_src_ptr1,
  input  wire logic [DDS_ADDR_W-1:0] i_dst_ptr1,
  input  wire logic [DDS_CNT_W-1:0]  i_reload1,
  input  wire logic [5:0]            i_src_rgn,
  input  wire logic [5:0]            i_dst_rgn,
  // cpu bus access done, one pulse per cpu access
  input  wire logic                  i_cpu_access_done,
  // status and bus outputs
  output logic      [1:0]            o_enable,
  output logic      [1:0]            o_req,
  output logic                       o_bus_grant,
  output logic                       o_active_ch,
  output logic                       o_unit_done,
  output logic      [DDS_ADDR_W-1:0] o_fwd_ptr0,
  output logic      [DDS_ADDR_W-1:0] o_fwd_ptr1,
  output logic      [DDS_CNT_W-1:0]  o_count0,
  output logic      [DDS_CNT_W-1:0]  o_count1,
  output logic      [DDS_CYC_W-1:0]  o_unit_cycles
);
  ////////////////////////////////////////////////////////////////////////
  // signals
  dds_state_t                        state;
  dds_state_t                        next_state;
  logic       [1:0]                  enable;
  logic       [1:0]                  fresh;
  logic       [1:0]                  req;
  logic       [1:0]                  start_clr;
  logic       [DDS_ADDR_W-1:0]       fwd_ptr [2];
  logic       [DDS_CNT_W-1:0]        count   [2];
  logic       [DDS_CYC_W-1:0]        cyc_left;
  logic       [DDS_CYC_W-1:0]        unit_cycles;
  logic                              active_ch;
  logic                              bus_grant;
  logic                              unit_done;
  logic       [1:0]                  ready;
  logic                              pick_any;
  logic                              pick_ch;
  logic       [DDS_CYC_W-1:0]        calc_cyc [2];
  logic       [1:0]                  calc_bad;
  logic       [DDS_ADDR_W-1:0]       src_ptr [2];
  logic       [DDS_ADDR_W-1:0]       dst_ptr [2];
  logic       [DDS_CNT_W-1:0]        reload  [2];
  logic       [DDS_ADDR_W-1:0]       load_ptr [2];
  logic                              bus8;
  logic                              last_cyc;

  ////////////////////////////////////////////////////////////////////////
  // per channel request latch and cycle calculation
  assign src_ptr[0] = i_src_ptr0;
  assign src_ptr[1] = i_src_ptr1;
  assign dst_ptr[0] = i_dst_ptr0;
  assign dst_ptr[1] = i_dst_ptr1;
  assign reload[0]  = i_reload0;
  assign reload[1]  = i_reload1;
  // in single-chip mode the pin does not narrow the bus; otherwise it covers
  // internal areas too
  assign bus8 = i_bus8_pin && (i_proc_mode != DDS_MODE_SINGLE);      // R06 R19

  for (genvar c = 0; c < DDS_NUM_CH; c++)
  begin : g_ch
    dds_req_latch i_dds_req_latch (
      .i_core_clk             (i_core_clk),
      .i_rstn                 (i_rstn),
      .i_src_sel              (i_src_sel[2*c +: 2]),
      .i_periph_irq           (i_periph_irq[c]),
      .i_soft_trig            (i_soft_trig[c]),
      .i_external_request_pin (i_external_request_pin[c]),
      .i_sw_clr               (i_req_wr0[c]),
      .i_start_clr            (start_clr[c]),
      .o_req                  (req[c])
    );
    dds_cycle_calc i_dds_cycle_calc (
      .i_src_addr      (fresh[c] ? src_ptr[c] : fwd_ptr[c]),
      .i_dst_addr      (dst_ptr[c]),
      .i_unit_size_bit (i_unit_size_bit[c]),
      .i_bus8          (bus8),
      .i_src_rgn       (i_src_rgn[3*c +: 3]),
      .i_dst_rgn       (i_dst_rgn[3*c +: 3]),
      .o_cycles        (calc_cyc[c]),
      .o_illegal       (calc_bad[c])
    );
    assign load_ptr[c] = i_dir_from_src[c] ? src_ptr[c] : dst_ptr[c];
  end

  ////////////////////////////////////////////////////////////////////////
  // arbitration: channel 0 wins ties; cpu flag plays no part
  assign ready     = req & enable & ~calc_bad;                       // R18
  assign pick_any  = |ready;
  assign pick_ch   = ~ready[0];                                      // R16
  assign last_cyc  = (cyc_left == 4'h1);

  always_comb
  begin
    next_state = state;
    start_clr  = 2'h0;
    unique case (state)
      DDS_ST_IDLE:
        if (pick_any)
        begin
          next_state         = DDS_ST_XFER;
          start_clr[pick_ch] = 1'b1;                                 // R10
        end
      DDS_ST_XFER:
        if (last_cyc)
          next_state = DDS_ST_CPU;                                   // R17 R20
      DDS_ST_CPU:
        next_state = DDS_ST_HOLD;
      DDS_ST_HOLD:
        if (i_cpu_access_done)
          next_state = DDS_ST_IDLE;                                  // R17
      default:
        next_state = DDS_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state and bus grant
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state       <= DDS_ST_IDLE;
      active_ch   <= 1'b0;
      cyc_left    <= 4'h0;
      unit_cycles <= 4'h0;
      bus_grant   <= 1'b0;
      unit_done   <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      unit_done <= (state == DDS_ST_XFER) && last_cyc;
      bus_grant <= (next_state == DDS_ST_XFER);
      if (state == DDS_ST_IDLE && pick_any)
      begin
        active_ch   <= pick_ch;
        cyc_left    <= calc_cyc[pick_ch];                            // R02
        unit_cycles <= calc_cyc[pick_ch];
      end
      else if (state == DDS_ST_XFER && !last_cyc)
        cyc_left <= cyc_left - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable, pointer and counter per channel
  for (genvar c = 0; c < DDS_NUM_CH; c++)
  begin : g_ctl
    logic starting;
    assign starting = (state == DDS_ST_IDLE) && pick_any && (pick_ch == 1'(c));
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
      if (!i_rstn)
      begin
        enable[c]  <= 1'b0;
        fresh[c]   <= 1'b0;
        fwd_ptr[c] <= '0;
        count[c]   <= '0;
      end
      else if (i_enable_wr[c])
      begin
        enable[c] <= i_enable_val[c];
        fresh[c]  <= i_enable_val[c];                                // R08
      end
      else if (starting)
      begin
        // first unit after enable reloads both; later units step on
        if (fresh[c])
        begin
          fwd_ptr[c] <= load_ptr[c] + (i_unit_size_bit[c] ? 20'h1 : 20'h2); // R07
          count[c]   <= reload[c];                                   // R07
        end
        else
        begin
          fwd_ptr[c] <= fwd_ptr[c] + (i_unit_size_bit[c] ? 20'h1 : 20'h2);
          count[c]   <= count[c] - 16'h1;
        end
        fresh[c] <= 1'b0;
        if (!fresh[c] && count[c] == 16'h0)
          enable[c] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_enable      <= 2'h0;
      o_req         <= 2'h0;
      o_bus_grant   <= 1'b0;
      o_active_ch   <= 1'b0;
      o_unit_done   <= 1'b0;
      o_fwd_ptr0    <= '0;
      o_fwd_ptr1    <= '0;
      o_count0      <= '0;
      o_count1      <= '0;
      o_unit_cycles <= 4'h0;
    end
    else
    begin
      o_enable      <= enable;
      o_req         <= req;
      o_bus_grant   <= bus_grant;
      o_active_ch   <= active_ch;
      o_unit_done   <= unit_done;
      o_fwd_ptr0    <= fwd_ptr[0];
      o_fwd_ptr1    <= fwd_ptr[1];
      o_count0      <= count[0];
      o_count1      <= count[1];
      o_unit_cycles <= unit_cycles;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_tie_ch0;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && ready == 2'h3) |=> (active_ch == 1'b0);
  endproperty
  a_tie_ch0: assert property (p_tie_ch0) else $error("channel 1 won a tie"); // R16

  property p_cpu_between;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_XFER && last_cyc) |=> (state == DDS_ST_CPU) ##1 (state == DDS_ST_HOLD);
  endproperty
  a_cpu_between: assert property (p_cpu_between) else $error("bus not handed back"); // R17

  property p_clear_start;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && pick_any && !i_periph_irq[pick_ch] && !i_soft_trig[pick_ch]
     && i_src_sel[2*pick_ch +: 2] < DDS_SRC_EXT_FALL) |=> !req[active_ch];
  endproperty
  a_clear_start: assert property (p_clear_start) else $error("request not cleared"); // R10

  property p_cycles;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && pick_any) |=> (cyc_left >= 4'h2 && cyc_left <= 4'h0c);
  endproperty
  a_cycles: assert property (p_cycles) else $error("unit cycle count out of range"); // R02

  property p_one_unit;
    @(posedge i_core_clk) disable iff (!i_rstn)
    $rose(bus_grant) |-> ##[1:12] !bus_grant;
  endproperty
  a_one_unit: assert property (p_one_unit) else $error("grant held too long"); // R20

  property p_reload;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && pick_any && fresh[pick_ch] && !i_enable_wr[pick_ch])
      |=> (count[active_ch] == $past(reload[pick_ch]));
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded"); // R07

  property p_restart;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_enable_wr[0] && i_enable_val[0]) |=> fresh[0];
  endproperty
  a_restart: assert property (p_restart) else $error("enable rewrite did not restart"); // R08

  property p_sw_clear;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_req_wr0[1] && !i_periph_irq[1] && !i_soft_trig[1] && i_src_sel[3:2] < DDS_SRC_EXT_FALL)
      |=> !req[1];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear ignored"); // R11

  // the cpu flag is read only here: arbitration must not depend on it
  property p_if_ignored;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && pick_any && !i_cpu_if_flag) |=> (state == DDS_ST_XFER);
  endproperty
  a_if_ignored: assert property (p_if_ignored) else $error("cpu flag blocked a transfer"); // R18

  property p_hold_cpu;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_HOLD && !i_cpu_access_done) |=> (state == DDS_ST_HOLD);
  endproperty
  a_hold_cpu: assert property (p_hold_cpu) else $error("bus taken before cpu access"); // R17

  property p_req_set;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_soft_trig[1] && i_src_sel[3:2] == DDS_SRC_SOFT) |=> req[1];
  endproperty
  a_req_set: assert property (p_req_set) else $error("soft request lost"); // R09

  property p_byte_unit;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && pick_any && i_unit_size_bit[pick_ch]) |=> (cyc_left <= 4'h6);
  endproperty
  a_byte_unit: assert property (p_byte_unit) else $error("byte unit too long"); // R04

  property p_lone_ch1;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (state == DDS_ST_IDLE && ready == 2'h2) |=> (active_ch == 1'b1);
  endproperty
  a_lone_ch1: assert property (p_lone_ch1) else $error("lone channel 1 not served"); // R16
endmodule
`default_nettype wire

/* File: dds_cpu_model.sv */
// cpu bus master model: one bus access after each dma unit, prompt or slow
`default_nettype none
module dds_cpu_model
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  // dma side
  input  wire logic i_unit_done,
  input  wire logic i_slow,
  // access finished
  output var  logic o_cpu_access_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // the cpu takes its single access only once the dma unit has ended
  always @(negedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wait_cnt          <= 3'h0;
      o_cpu_access_done <= 1'b0;
    end
    else
    begin
      // one-cycle done pulse as the count runs out
      o_cpu_access_done <= (wait_cnt == 3'h1);
      if (wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
      else if (i_unit_done)
        wait_cnt <= i_slow ? 3'h6 : 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: test_dual_channel_dma_sequencer.sv */
// self-checking bench for the dual channel dma sequencer
`default_nettype none
module test_dual_channel_dma_sequencer;
  import dds_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0, i_rstn = 1'b0, i_bus8_pin = 1'b0, i_cpu_if_flag = 1'b1;
  logic i_cpu_access_done, slow = 1'b0;
  logic [1:0] i_proc_mode = 2'h0, i_enable_wr = 2'h0, i_enable_val = 2'h0, i_req_wr0 = 2'h0;
  logic [1:0] i_unit_size_bit = 2'h0, i_dir_from_src = 2'h3, i_soft_trig = 2'h0;
  // pins idle high, the level the edge detector assumes after reset
  logic [1:0] i_periph_irq = 2'h0, i_external_request_pin = 2'h3;
  logic [3:0] i_src_sel = 4'h5;
  logic [DDS_ADDR_W-1:0] i_src_ptr0 = '0, i_dst_ptr0 = '0, i_src_ptr1 = '0, i_dst_ptr1 = '0;
  logic [DDS_CNT_W-1:0] i_reload0 = 16'h0010, i_reload1 = 16'h0010;
  logic [5:0] i_src_rgn = 6'h0, i_dst_rgn = 6'h0;
  logic [1:0] o_enable, o_req;
  logic o_bus_grant, o_active_ch, o_unit_done;
  logic [DDS_ADDR_W-1:0] o_fwd_ptr0, o_fwd_ptr1;
  logic [DDS_CNT_W-1:0] o_count0, o_count1;
  logic [DDS_CYC_W-1:0] o_unit_cycles;
  int err_total = 0, checks = 0;
  int e;
  logic seen;
  always #2 i_core_clk = ~i_core_clk;
  dds_sequencer i_dds_sequencer (.i_core_clk, .i_rstn, .i_proc_mode, .i_bus8_pin, .i_cpu_if_flag,
    .i_enable_wr, .i_enable_val, .i_req_wr0, .i_unit_size_bit, .i_dir_from_src, .i_soft_trig,
    .i_periph_irq, .i_external_request_pin, .i_src_sel, .i_src_ptr0, .i_dst_ptr0, .i_reload0,
    .i_src_ptr1, .i_dst_ptr1, .i_reload1, .i_src_rgn, .i_dst_rgn, .i_cpu_access_done,
    .o_enable, .o_req, .o_bus_grant, .o_active_ch, .o_unit_done, .o_fwd_ptr0,
    .o_fwd_ptr1, .o_count0, .o_count1, .o_unit_cycles);
  dds_cpu_model i_dds_cpu_model (.i_core_clk, .i_rstn, .i_unit_done(o_unit_done),
    .i_slow(slow), .o_cpu_access_done(i_cpu_access_done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // bounded wait on grant (0), unit end (1) or cpu access end (2)
  task automatic wt(input int s);
    int n;
    n = 0;
    while (((s == 0) ? o_bus_grant : (s == 1) ? o_unit_done : i_cpu_access_done) !== 1'b1)
    begin
      if (n == 100)
      begin
        chk("wait", 1, s + 2);
        conclude();
      end
      cyc(1);
      n++;
    end
  endtask
  task automatic enable(input int ch, input logic v);
    i_enable_wr[ch] = 1'b1;
    i_enable_val[ch] = v;
    cyc(1);
    i_enable_wr = 2'h0;
  endtask
  task automatic clr(input int ch);
    i_req_wr0[ch] = 1'b1;
    cyc(1);
    i_req_wr0 = 2'h0;
    cyc(2);
  endtask
  // one software-triggered unit; checks grant owner, cycle count, request clear
  task automatic xfer(input int ch, input int x);
    i_soft_trig[ch] = 1'b1;
    cyc(1);
    i_soft_trig = 2'h0;
    wt(0);
    chk("active_ch", ch, o_active_ch);
    chk("unit_cycles", x, o_unit_cycles);
    chk("req_at_start", 0, o_req[ch]);
    wt(1);
    wt(2);
    cyc(1);
  endtask
  function automatic int coef(input int r);
    return (r == 0 || r == 3) ? 1 : (r == 5) ? 3 : 2;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(12);
    i_rstn = 1'b1;
    chk("req_rst", 0, o_req);
    chk("grant_rst", 0, o_bus_grant);
    // word units, every region class, even and odd addresses, each mode
    for (int r = 0; r < 6; r++)
      for (int odd = 0; odd < 2; odd++)
      begin
        i_proc_mode = 2'(r % 3);
        i_src_rgn = 6'(r);
        i_dst_rgn = 6'(5 - r);
        i_src_ptr0 = 20'h00100 | 20'(odd);
        i_dst_ptr0 = 20'h00200 | 20'(odd);
        i_dir_from_src = {1'b1, 1'(odd)};
        enable(0, 1'b1);
        cyc(1);
        chk("enable", 1, o_enable[0]);
        e = (odd + 1) * (coef(r) + coef(5 - r));
        xfer(0, e);
        // odd reloads from the source pointer, even from the destination; a word steps 2
        chk("fwd_ptr", (odd == 1) ? 32'h00103 : 32'h00202, o_fwd_ptr0);
        chk("count", 32'h0010, o_count0);
      end
    // byte units at odd and even addresses: one read and one write whatever mode or width pin
    i_unit_size_bit = 2'h3;
    for (int m = 0; m < 6; m++)
    begin
      i_proc_mode = 2'(m % 3);
      i_bus8_pin = m[0];
      i_src_rgn = 6'(m);
      i_dst_rgn = 6'h5;
      xfer(0, coef(m) + 3);
    end
    i_unit_size_bit = 2'h0;
    i_bus8_pin = 1'b0;
    i_proc_mode = 2'h0;
    i_src_rgn = 6'h0;
    i_dst_rgn = 6'h0;
    // word units, even addresses, width pin high: narrows only outside single-chip mode
    i_bus8_pin = 1'b1;
    i_src_ptr0 = 20'h00100;
    i_dst_ptr0 = 20'h00200;
    for (int m = 0; m < 3; m++)
    begin
      i_proc_mode = 2'(m);
      enable(0, 1'b1);
      xfer(0, (m == 0) ? 2 : 4);
    end
    i_bus8_pin = 1'b0;
    i_proc_mode = 2'h0;
    // disabled channel 1: each source kind sets the request bit
    i_src_sel = 4'h1;
    clr(1);
    i_periph_irq[1] = 1'b1;
    cyc(1);
    i_periph_irq = 2'h0;
    cyc(2);
    chk("req_periph", 1, o_req[1]);
    chk("no_grant", 0, o_bus_grant);
    clr(1);
    chk("req_sw_clr", 0, o_req[1]);
    i_src_sel = 4'h9;
    clr(1);
    i_external_request_pin[1] = 1'b0;
    cyc(3);
    chk("req_fall", 1, o_req[1]);
    clr(1);
    i_external_request_pin[1] = 1'b1;
    cyc(3);
    chk("req_wrong_edge", 0, o_req[1]);
    i_src_sel = 4'hd;
    clr(1);
    i_external_request_pin[1] = 1'b0;
    cyc(3);
    chk("req_no_rise", 0, o_req[1]);
    i_external_request_pin[1] = 1'b1;
    cyc(3);
    chk("req_rise", 1, o_req[1]);
    i_src_sel = 4'h5;
    clr(1);
    i_soft_trig[1] = 1'b1;
    cyc(1);
    i_soft_trig = 2'h0;
    cyc(2);
    chk("req_soft", 1, o_req[1]);
    clr(1);
    // simultaneous requests, slow cpu, interrupt flag cleared
    i_cpu_if_flag = 1'b0;
    slow = 1'b1;
    enable(1, 1'b1);
    i_soft_trig = 2'h3;
    cyc(1);
    i_soft_trig = 2'h0;
    wt(0);
    chk("first_ch", 0, o_active_ch);
    wt(1);
    seen = 1'b0;
    for (int n = 0; n < 60 && o_bus_grant !== 1'b1; n++)
    begin
      seen = seen | (i_cpu_access_done === 1'b1);
      cyc(1);
    end
    chk("second_ch", 1, o_active_ch);
    chk("cpu_between", 1, seen);
    wt(1);
    wt(2);
    cyc(2);
    chk("fwd_ptr1", 32'h00002, o_fwd_ptr1);
    chk("count1", 32'h0010, o_count1);
    // illegal region class blocks the channel
    i_src_rgn = 6'h6;
    i_soft_trig[0] = 1'b1;
    cyc(1);
    i_soft_trig = 2'h0;
    cyc(20);
    chk("illegal_rgn", 0, o_bus_grant);
    conclude();
  end
endmodule
`default_nettype wire
